/* File: logic/logic_cluster_defs.vh */
`ifndef LOGIC_CLUSTER_DEFS_VH
`define LOGIC_CLUSTER_DEFS_VH

// cluster geometry
`define LC_CELLS 10
`define LC_ROUTE_SRCS 30
`define LC_ROUTE_SEL_W 5
`define LC_ROW_CLOCKS 6
`define LC_ROW_SEL_W 3
`define LC_CLUSTER_CLOCKS 3
`define LC_CLOCK_SOURCES 2
`define LC_ASYNC_CLEARS 2

// control signal budget and status layout
`define LC_CTRL_MAX 10
`define LC_CTRL_CLK_LSB 0
`define LC_CTRL_ENA_LSB 3
`define LC_CTRL_ACLR_LSB 6
`define LC_CTRL_SCLR_BIT 8
`define LC_CTRL_SLOAD_BIT 9

// memory variant
`define LC_MEM_BITS 640
`define LC_MEM_DEPTH 64
`define LC_MEM_ADDR_W 6
`define LC_MEM_WIDE_DEPTH 32
`define LC_MEM_DATA_W 20

// cell clock select code meaning no clock
`define LC_CLK_SEL_NONE 2'h3

// reset values
`define LC_CELL_RESET 1'h0
`define LC_CTRL_RESET 10'h000
`define LC_TICK_RESET 3'h0

`endif

/* File: logic/logic_cell.v */
`timescale 1ns/100ps
`include "logic_cluster_defs.vh"

// one cell: register with cluster controls plus a 64 x 1 / 32 x 2 memory slice
module logic_cell #(
  parameter DEPTH = `LC_MEM_DEPTH,
  parameter AW = `LC_MEM_ADDR_W
) (
  input wire clock_i,
  input wire aclr_n_i,
  input wire tick_i,
  input wire sclr_i,
  input wire sload_i,
  input wire load_d_i,
  input wire d_i,
  input wire use_chain_i,
  input wire chain_i,
  input wire mem_en_i,
  input wire mem_wide_i,
  input wire mem_we_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [1:0] wr_data_i,
  input wire [AW-1:0] rd_addr_i,
  output reg q_o,
  output reg [1:0] rd_q_o
);

  reg [DEPTH-1:0] mem;
  reg q_d;

  // next register value: sync clear beats sync load beats data
  always @* begin
    if (sclr_i) begin
      q_d = `LC_CELL_RESET;
    end else if (sload_i) begin
      q_d = load_d_i;
    end else if (use_chain_i) begin
      q_d = chain_i;
    end else begin
      q_d = d_i;
    end
  end

  // async clear overrides clock, enable and sync controls
  always @(posedge clock_i or negedge aclr_n_i) begin
    if (!aclr_n_i) begin
      q_o <= `LC_CELL_RESET;
    end else if (tick_i) begin
      q_o <= q_d;
    end
  end

  // memory write port; storage is not reset, contents are undefined at power up
  always @(posedge clock_i) begin
    if (mem_en_i && mem_we_i) begin
      if (mem_wide_i) begin
        mem[{wr_addr_i[AW-2:0], 1'b0}] <= wr_data_i[0];
        mem[{wr_addr_i[AW-2:0], 1'b1}] <= wr_data_i[1];
      end else begin
        mem[wr_addr_i] <= wr_data_i[0];
      end
    end
  end

  // separate read port, registered; a cell outside memory mode reads zero
  always @(posedge clock_i or negedge aclr_n_i) begin
    if (!aclr_n_i) begin
      rd_q_o <= 2'h0;
    end else if (!mem_en_i) begin
      rd_q_o <= 2'h0;
    end else if (mem_wide_i) begin
      rd_q_o <= {mem[{rd_addr_i[AW-2:0], 1'b1}], mem[{rd_addr_i[AW-2:0], 1'b0}]};
    end else begin
      rd_q_o <= {1'b0, mem[rd_addr_i]};
    end
  end

endmodule // logic_cell

/* File: logic/logic_cluster.v */
`timescale 1ns/100ps
`include "logic_cluster_defs.vh"

// Notes on behaviour
// - The cluster holds ten cells that share one control block, local routing and register-chain links.
// - A chain link feeds each cell register's output straight into the next cell's register.
// - In memory use the cluster stores at most 640 bits with one write port and one separate read port.
// - Each memory cell is a 64 x 1 or 32 x 2 slice, and the ten slices make one wider memory.
// - A cell not set up as memory behaves exactly like an ordinary logic cell.
// - Local routing takes the own cells and the left and right neighbours, thirty sources in all.
// - The control block drives at most ten control signals to its cells at once.
// - The controls are three clocks, three clock enables, two async clears, one sync clear and sync load.
// - Up to three cluster clocks come from two clock sources combined with three enables.
// - Each cluster clock is tied to its own enable, so a cell on clock one is gated by enable one.
// - Using both edges of a source costs two of the three cluster clocks.
// - A low clock enable stops its cluster clock so no register on it updates.
// - The two cluster clock sources are taken from six row clock lines and from local routing.
// - Each cell register takes data, clock, enable, sync and async clear and sync load.
// - The cluster controls stay available to the cell registers in every cell mode.
module logic_cluster #(
  parameter CELLS = `LC_CELLS,
  parameter ROWS = `LC_ROW_CLOCKS,
  parameter AW = `LC_MEM_ADDR_W
) (
  input wire clock_i,
  input wire arst_n_i,
  input wire [ROWS-1:0] row_clock_i,
  input wire [CELLS-1:0] left_i,
  input wire [CELLS-1:0] right_i,
  input wire chain_i,
  input wire [5:0] src_row_sel_i,
  input wire [1:0] src_local_i,
  input wire [9:0] src_local_sel_i,
  input wire [2:0] cclk_src_i,
  input wire [2:0] cclk_fall_i,
  input wire [2:0] cluster_clock_gate_i,
  input wire [1:0] aclr_i,
  input wire sclr_i,
  input wire sload_i,
  input wire [19:0] cell_clk_sel_i,
  input wire [9:0] cell_aclr_sel_i,
  input wire [9:0] cell_aclr_use_i,
  input wire [9:0] cell_sclr_use_i,
  input wire [9:0] cell_sload_use_i,
  input wire [49:0] cell_data_sel_i,
  input wire [49:0] cell_load_sel_i,
  input wire [9:0] cell_use_chain_i,
  input wire [9:0] cell_mem_i,
  input wire mem_wide_i,
  input wire mem_we_i,
  input wire [AW-1:0] mem_wr_addr_i,
  input wire [`LC_MEM_DATA_W-1:0] mem_wr_data_i,
  input wire [AW-1:0] mem_rd_addr_i,
  output wire [CELLS-1:0] cell_q_o,
  output wire chain_o,
  output reg [`LC_MEM_DATA_W-1:0] mem_rd_data_o,
  output reg [2:0] cluster_tick_o,
  output reg [`LC_CTRL_MAX-1:0] ctrl_used_o
);

  // pick one of the thirty local routing sources; out of range reads zero
  function route_pick;
    input [`LC_ROUTE_SRCS-1:0] vec;
    input [`LC_ROUTE_SEL_W-1:0] sel;
    begin
      if (sel < `LC_ROUTE_SRCS) begin
        route_pick = vec[sel];
      end else begin
        route_pick = 1'b0;
      end
    end
  endfunction

  // pick one of the row clock lines; out of range reads zero
  function row_pick;
    input [ROWS-1:0] vec;
    input [`LC_ROW_SEL_W-1:0] sel;
    begin
      if (sel < ROWS) begin
        row_pick = vec[sel];
      end else begin
        row_pick = 1'b0;
      end
    end
  endfunction

  wire [CELLS-1:0] q;
  wire [`LC_ROUTE_SRCS-1:0] local_route;
  wire [CELLS:0] chain;
  wire [2*CELLS-1:0] rd_q;
  reg [1:0] src_level;
  reg [1:0] src_prev_q;
  reg [1:0] src_rise;
  reg [1:0] src_fall;
  reg [2:0] tick;
  reg [`LC_CTRL_MAX-1:0] ctrl_used_d;
  reg [`LC_MEM_DATA_W-1:0] rd_data_d;
  integer s;
  integer k;
  integer c;
  integer m;

  // own cells, left and right neighbours on direct links
  assign local_route = {right_i, left_i, q};

  // chain links run cell to cell in order, first cell fed from outside
  assign chain[0] = chain_i;
  assign chain[CELLS:1] = q;
  assign cell_q_o = q;
  assign chain_o = q[CELLS-1];

  // each of the two clock sources comes from a row line or local routing
  always @* begin
    for (s = 0; s < `LC_CLOCK_SOURCES; s = s + 1) begin
      if (src_local_i[s]) begin
        src_level[s] = route_pick(local_route, src_local_sel_i[s*5 +: 5]);
      end else begin
        src_level[s] = row_pick(row_clock_i, src_row_sel_i[s*3 +: 3]);
      end
    end
  end

  // previous source levels for edge detection
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_prev_q <= 2'h0;
    end else begin
      src_prev_q <= src_level;
    end
  end

  // sources are sampled levels, so edges show as one-cycle ticks
  always @* begin
    src_rise = src_level & ~src_prev_q;
    src_fall = ~src_level & src_prev_q;
  end

  // cluster clocks: source edge gated by the clock's own enable
  always @* begin
    for (k = 0; k < `LC_CLUSTER_CLOCKS; k = k + 1) begin
      if (cclk_fall_i[k]) begin
        tick[k] = src_fall[cclk_src_i[k]] & cluster_clock_gate_i[k];
      end else begin
        tick[k] = src_rise[cclk_src_i[k]] & cluster_clock_gate_i[k];
      end
    end
  end

  // cells and their control hook-up
  genvar g;
  generate
    for (g = 0; g < CELLS; g = g + 1) begin : cell_gen
      wire [1:0] clk_sel = cell_clk_sel_i[2*g +: 2];
      // the enable travels with the chosen clock, never chosen apart from it
      wire cell_tick = (clk_sel == `LC_CLK_SEL_NONE) ? 1'b0 : tick[clk_sel];
      // async clear reaches the cell combinationally, no clock edge needed
      wire cell_aclr = cell_aclr_use_i[g] & aclr_i[cell_aclr_sel_i[g]];
      wire cell_aclr_n = arst_n_i & ~cell_aclr;
      wire [1:0] wr_slice = mem_wide_i ? mem_wr_data_i[2*g +: 2] : {1'b0, mem_wr_data_i[g]};

      logic_cell #(
        .DEPTH(`LC_MEM_DEPTH),
        .AW(AW)
      ) cell_u (
        .clock_i(clock_i),
        .aclr_n_i(cell_aclr_n),
        .tick_i(cell_tick),
        .sclr_i(sclr_i & cell_sclr_use_i[g]),
        .sload_i(sload_i & cell_sload_use_i[g]),
        .load_d_i(route_pick(local_route, cell_load_sel_i[5*g +: 5])),
        .d_i(route_pick(local_route, cell_data_sel_i[5*g +: 5])),
        .use_chain_i(cell_use_chain_i[g]),
        .chain_i(chain[g]),
        .mem_en_i(cell_mem_i[g]),
        .mem_wide_i(mem_wide_i),
        .mem_we_i(mem_we_i & tick[0]),
        .wr_addr_i(mem_wr_addr_i),
        .wr_data_i(wr_slice),
        .rd_addr_i(mem_rd_addr_i),
        .q_o(q[g]),
        .rd_q_o(rd_q[2*g +: 2])
      );
    end
  endgenerate

  // read data: 64 x 10 narrow or 32 x 20 wide, 640 bits either way
  always @* begin
    rd_data_d = {`LC_MEM_DATA_W{1'b0}};
    for (m = 0; m < CELLS; m = m + 1) begin
      if (mem_wide_i) begin
        rd_data_d[2*m +: 2] = rd_q[2*m +: 2];
      end else begin
        rd_data_d[m] = rd_q[2*m];
      end
    end
  end

  // which of the ten control signals some cell is using right now
  always @* begin
    ctrl_used_d = `LC_CTRL_RESET;
    for (c = 0; c < CELLS; c = c + 1) begin
      if (cell_clk_sel_i[2*c +: 2] != `LC_CLK_SEL_NONE) begin
        ctrl_used_d[`LC_CTRL_CLK_LSB + cell_clk_sel_i[2*c +: 2]] = 1'b1;
        ctrl_used_d[`LC_CTRL_ENA_LSB + cell_clk_sel_i[2*c +: 2]] = 1'b1;
      end
      if (cell_aclr_use_i[c]) begin
        ctrl_used_d[`LC_CTRL_ACLR_LSB + cell_aclr_sel_i[c]] = 1'b1;
      end
      if (cell_sclr_use_i[c]) begin
        ctrl_used_d[`LC_CTRL_SCLR_BIT] = 1'b1;
      end
      if (cell_sload_use_i[c]) begin
        ctrl_used_d[`LC_CTRL_SLOAD_BIT] = 1'b1;
      end
    end
  end

  // status and read data registered so every output leaves a flop;
  // the map has exactly ten slots, so the budget cannot be exceeded
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_used_o <= `LC_CTRL_RESET;
      cluster_tick_o <= `LC_TICK_RESET;
      mem_rd_data_o <= {`LC_MEM_DATA_W{1'b0}};
    end else begin
      ctrl_used_o <= ctrl_used_d;
      cluster_tick_o <= tick;
      mem_rd_data_o <= rd_data_d;
    end
  end

endmodule // logic_cluster

/* File: dv/logic_cluster_monitor.sv */
`timescale 1ns/100ps
module logic_cluster_monitor #(parameter CELLS = 10) (
  input wire clock_i,
  input wire arst_n_i,
  input wire [CELLS-1:0] left_i,
  input wire [CELLS-1:0] right_i,
  input wire chain_i,
  input wire [5:0] src_row_sel_i,
  input wire [1:0] src_local_i,
  input wire [9:0] src_local_sel_i,
  input wire [2:0] cclk_src_i,
  input wire [2:0] cclk_fall_i,
  input wire [2:0] cluster_clock_gate_i,
  input wire [1:0] aclr_i,
  input wire sclr_i,
  input wire sload_i,
  input wire [19:0] cell_clk_sel_i,
  input wire [9:0] cell_aclr_sel_i,
  input wire [9:0] cell_aclr_use_i,
  input wire [9:0] cell_sclr_use_i,
  input wire [9:0] cell_sload_use_i,
  input wire [49:0] cell_data_sel_i,
  input wire [49:0] cell_load_sel_i,
  input wire [9:0] cell_use_chain_i,
  input wire [9:0] cell_mem_i,
  input wire [CELLS-1:0] cell_q_o,
  input wire [2:0] cluster_tick_o,
  input wire [9:0] ctrl_used_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // routing picks of 30 and 31 read zero
  wire [31:0] route = {2'h0, right_i, left_i, cell_q_o};
  reg up_q;
  // first edge after reset still sees reset-time config through $past
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) up_q <= 1'h0;
    else up_q <= 1'h1;
  end
  // edges of unchanged tick sources; a changed source or direction may tick twice in a row
  wire [23:0] tick_cfg = {src_row_sel_i, src_local_i, src_local_sel_i, cclk_src_i, cclk_fall_i};
  reg [23:0] tick_cfg_q;
  reg [1:0] cfg_same_q;
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cfg_q <= 24'h000000;
      cfg_same_q <= 2'h0;
    end else begin
      tick_cfg_q <= tick_cfg;
      if (tick_cfg != tick_cfg_q) cfg_same_q <= 2'h0;
      else if (cfg_same_q != 2'h3) cfg_same_q <= cfg_same_q + 2'h1;
    end
  end
  genvar c;
  generate for (c = 0; c < CELLS; c = c + 1) begin : g
    reg [1:0] ks_q;
    reg mem_q, sc_q, sl_q, ch_q, dv_q, lv_q, pv_q, clr_q;
    wire prev = (c == 0) ? chain_i : cell_q_o[(c + CELLS - 1) % CELLS];
    wire clr = cell_aclr_use_i[c] & aclr_i[cell_aclr_sel_i[c]];
    // what the cell saw at the edge that may have loaded it
    always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) {ks_q, mem_q, sc_q, sl_q, ch_q, dv_q, lv_q, pv_q, clr_q} <= 10'h000;
      else {ks_q, mem_q, sc_q, sl_q, ch_q, dv_q, lv_q, pv_q, clr_q} <= {cell_clk_sel_i[2*c+:2], cell_mem_i[c],
        sclr_i & cell_sclr_use_i[c], sload_i & cell_sload_use_i[c], cell_use_chain_i[c],
        route[cell_data_sel_i[5*c+:5]], route[cell_load_sel_i[5*c+:5]], prev, clr};
    end
    wire hit = ks_q != 2'h3 && cluster_tick_o[ks_q];
    wire tk = hit && !mem_q && !clr && !clr_q;
    chk_aclr_clears: assert property (clr |-> !cell_q_o[c]) else $error("cell not cleared");
    chk_sclr_first: assert property (tk && sc_q |-> !cell_q_o[c]) else $error("sync clear lost");
    chk_sload_value: assert property (tk && !sc_q && sl_q |-> cell_q_o[c] == lv_q)
      else $error("sync load value wrong");
    chk_chain_link: assert property (tk && !sc_q && !sl_q && ch_q |-> cell_q_o[c] == pv_q)
      else $error("chain value wrong");
    chk_data_path: assert property (tk && !sc_q && !sl_q && !ch_q |-> cell_q_o[c] == dv_q)
      else $error("data value wrong");
    chk_hold_untick: assert property (!clr && !mem_q && !hit |-> $stable(cell_q_o[c]))
      else $error("cell moved without tick");
  end endgenerate
  chk_gate_links: assert property ((cluster_tick_o & ~$past(cluster_clock_gate_i)) == 3'h0)
    else $error("tick with enable low");
  chk_tick_single: assert property (cfg_same_q >= 2'h2 |-> (cluster_tick_o & $past(cluster_tick_o)) == 3'h0)
    else $error("tick longer than one cycle");
  chk_enable_pair: assert property (ctrl_used_o[5:3] == ctrl_used_o[2:0]) else $error("enable unpaired");
  chk_sync_use: assert property (up_q |-> ctrl_used_o[9:8] == $past({|cell_sload_use_i, |cell_sclr_use_i}))
    else $error("sync control use wrong");
  cover property (cluster_tick_o[2]);
  cover property (ctrl_used_o[7:6] == 2'h3);
  cover property (|aclr_i ##1 !(|aclr_i));
endmodule // logic_cluster_monitor
bind logic_cluster logic_cluster_monitor #(.CELLS(CELLS)) mon (.*);

/* File: dv/neighbour_model.sv */
`timescale 1ns/100ps
module neighbour_model #(parameter SEED = 10'h155) (
  input wire clock_i,
  input wire arst_n_i,
  output reg [9:0] q_o
);
  // registered outputs of a neighbour; moved every cycle so no level sticks
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) q_o <= SEED;
    else q_o <= {q_o[8:0], ~q_o[9]} ^ {9'h000, q_o[3]};
  end
endmodule // neighbour_model

/* File: dv/logic_cluster_bench.sv */
`timescale 1ns/100ps
module logic_cluster_bench;
  logic clock_i = 1'h0, arst_n_i = 1'h0, chain_i = 1'h0, sclr_i = 1'h0, sload_i = 1'h0;
  logic mem_wide_i = 1'h0, mem_we_i = 1'h0;
  logic [5:0] row_clock_i = 6'h00, src_row_sel_i = 6'h08, mem_wr_addr_i = 6'h00, mem_rd_addr_i = 6'h00;
  logic [1:0] src_local_i = 2'h0, aclr_i = 2'h0;
  logic [9:0] src_local_sel_i = 10'h000, cell_aclr_sel_i = 10'h000, cell_aclr_use_i = 10'h000;
  logic [9:0] cell_sclr_use_i = 10'h000, cell_sload_use_i = 10'h000, cell_use_chain_i = 10'h000, cell_mem_i = 10'h000;
  logic [2:0] cclk_src_i = 3'h2, cclk_fall_i = 3'h4, cluster_clock_gate_i = 3'h7;
  logic [19:0] cell_clk_sel_i = 20'h00000, mem_wr_data_i = 20'h00000, msk;
  logic [49:0] cell_data_sel_i = 50'h0, cell_load_sel_i = 50'h0;
  wire [9:0] left_i, right_i, cell_q_o, ctrl_used_o;
  wire [19:0] mem_rd_data_o;
  wire [2:0] cluster_tick_o;
  wire chain_o;
  logic [31:0] rs = 32'hABB0;
  logic [9:0] lv;
  int n_mismatch = 0, total_checks = 0, cyc = 0, i;
  logic_cluster dut (.*);
  neighbour_model #(.SEED(10'h155)) lm (.clock_i(clock_i), .arst_n_i(arst_n_i), .q_o(left_i));
  neighbour_model #(.SEED(10'h2C3)) rm (.clock_i(clock_i), .arst_n_i(arst_n_i), .q_o(right_i));
  initial forever #5 clock_i = ~clock_i;
  function automatic [31:0] xs(input [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction
  // clock k also brings its enable; a clear counts only where a cell uses it
  function automatic [9:0] used_exp();
    used_exp = {|cell_sload_use_i, |cell_sclr_use_i, 8'h00};
    for (int c = 0; c < 10; c++) begin
      if (cell_clk_sel_i[2*c+:2] != 2'h3) used_exp[cell_clk_sel_i[2*c+:2]] = 1'h1;
      if (cell_clk_sel_i[2*c+:2] != 2'h3) used_exp[3 + cell_clk_sel_i[2*c+:2]] = 1'h1;
      if (cell_aclr_use_i[c]) used_exp[6 + cell_aclr_sel_i[c]] = 1'h1;
    end
  endfunction
  task automatic check(input [19:0] seen, input [19:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one rising then one falling row edge, called at a falling clock edge
  task automatic rise(input int k);
    row_clock_i[k] = 1'h1;
    @(negedge clock_i);
    row_clock_i[k] = 1'h0;
    @(negedge clock_i);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard well above the planned run length
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (16) @(negedge clock_i);
    check({cell_q_o, ctrl_used_o}, 20'h00000, "in reset");
    arst_n_i = 1'h1;
    for (i = 0; i < 10; i++) cell_data_sel_i[5*i+:5] = 5'(10 + i);
    for (i = 0; i < 10; i++) cell_load_sel_i[5*i+:5] = 5'(20 + i);
    @(negedge clock_i);
    // the status map is registered at the first edge after release
    check({cell_q_o, ctrl_used_o}, {10'h000, used_exp()}, "after reset");
    lv = left_i;
    rise(0);
    check(cell_q_o, lv, "rise load");
    check(cluster_tick_o, 3'h4, "fall tick");
    cluster_clock_gate_i = 3'h6;
    rise(0);
    check(cell_q_o, lv, "gated hold");
    cluster_clock_gate_i = 3'h7;
    cell_clk_sel_i = 20'h55555;
    lv = left_i;
    rise(1);
    check(cell_q_o, lv, "clock one");
    $display("clock test done");
    cell_clk_sel_i = 20'h00000;
    cell_sclr_use_i = 10'h3FF;
    cell_sload_use_i = 10'h3FF;
    {sclr_i, sload_i} = 2'h3;
    rise(0);
    check(cell_q_o, 10'h000, "clear over load");
    sclr_i = 1'h0;
    lv = right_i;
    rise(0);
    check(cell_q_o, lv, "sync load");
    {sload_i, chain_i, cell_use_chain_i} = {2'h1, 10'h3FF};
    rise(0);
    check(cell_q_o, {lv[8:0], 1'h1}, "chain");
    check(chain_o, lv[8], "chain out");
    {cell_aclr_use_i, cell_aclr_sel_i, aclr_i} = {20'hFFEAA, 2'h1};
    #1;
    check(cell_q_o, {lv[8:0], 1'h1} & 10'h2AA, "clear one");
    @(negedge clock_i);
    aclr_i = 2'h3;
    #1;
    check(cell_q_o, 10'h000, "clear both");
    @(negedge clock_i);
    aclr_i = 2'h0;
    check(ctrl_used_o, used_exp(), "used all");
    $display("control test done");
    {cell_mem_i, cell_aclr_use_i} = 20'hFFC00;
    for (i = 0; i < 2; i++) begin
      rs = xs(rs);
      mem_wide_i = i[0];
      msk = i ? 20'hFFFFF : 20'h003FF;
      mem_wr_addr_i = rs[5:0] & (i ? 6'h1F : 6'h3F);
      mem_wr_data_i = rs[25:6] & msk;
      {mem_we_i, row_clock_i[0]} = 2'h3;
      @(negedge clock_i);
      {mem_we_i, row_clock_i[0], mem_rd_addr_i} = {2'h0, mem_wr_addr_i};
      // cell read flop and output flop each add one cycle
      repeat (2) @(negedge clock_i);
      check(mem_rd_data_o & msk, mem_wr_data_i, "memory read");
    end
    cell_mem_i = 10'h000;
    repeat (2) @(negedge clock_i);
    check(mem_rd_data_o, 20'h00000, "no memory");
    $display("memory test done");
    for (i = 0; i < 3000; i++) begin
      @(negedge clock_i);
      check(ctrl_used_o, used_exp(), "used");
      rs = xs(rs);
      {row_clock_i, cluster_clock_gate_i, sclr_i, sload_i, chain_i, cell_clk_sel_i} = rs;
      rs = xs(rs);
      {cell_use_chain_i, cell_sclr_use_i, cell_sload_use_i} = rs[29:0];
      aclr_i = rs[31:30] & {2{&rs[29:27]}};
      {src_row_sel_i, cclk_src_i, cclk_fall_i, mem_wr_addr_i, mem_rd_addr_i} = rs[23:0];
      rs = xs(rs);
      cell_data_sel_i = {rs, rs[17:0]};
      {mem_we_i, mem_wide_i, mem_wr_data_i} = rs[21:0];
      rs = xs(rs);
      cell_load_sel_i = {rs[17:0], rs};
      {src_local_sel_i, src_local_i, cell_aclr_use_i, cell_aclr_sel_i} = rs;
    end
    $display("random test done");
    results();
  end
endmodule // logic_cluster_bench
